// ### inc/dcm_consts.svh
// Purpose: Constants for the disk controller mode and auxiliary command block.
// Assumes: Byte-wide register port, 50 MHz core clock.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef DCM_CONSTS_SVH
`define DCM_CONSTS_SVH
`define DCM_OFS_CMD 8'h00
`define DCM_OFS_PARAM 8'h04
`define DCM_OFS_RESULT 8'h08
`define DCM_OFS_STATUS 8'h0C
`define DCM_OFS_MODE 8'h10
`define DCM_OFS_LENH 8'h14
`define DCM_OFS_LENL 8'h18
`define DCM_OP_SPECIFY 5'h04
`define DCM_OP_SUS 5'h06
`define DCM_OP_SENSE_INT 5'h02
`define DCM_OP_DETECT_ERR 5'h0A
`define DCM_OP_AUX 4'h0
`define DCM_AUX_CLEAR_CMD_END 0
`define DCM_AUX_HOLD_SERVICE_REQ 1
`define DCM_AUX_CLB 2
`define DCM_AUX_RST 3
`define DCM_MB_ECC 6
`define DCM_MB_CRC_POLY_SELECT 5
`define DCM_MB_SECTOR_TYPE_SELECT 4
`define DCM_LB_CRC 6
`define DCM_LB_PAD 5
`define DCM_LB_POL 4
`define DCM_PAD_ZERO 8'h00
`define DCM_PAD_FILL 8'h4E
`define DCM_SUS_UST 8'h01
`define DCM_SUS_DS 8'h02
`define DCM_SUS_DT 8'h05
`define DCM_LEN_MIN_SOFT 12'h080
`define DCM_LEN_MIN_HARD 12'h100
`define DCM_STEP_BASE 16
`define DCM_STEP_UNIT 2110
`define DCM_ERR_TIME_US 100
`define DCM_CLK_MHZ 50
`define DCM_ERR_CYC (`DCM_ERR_TIME_US * `DCM_CLK_MHZ)
`define DCM_MODE_RST 8'h00
`define DCM_LENH_RST 8'h81
`define DCM_LENL_RST 8'h00
`endif

// ### inc/dcm_pkg.sv
// Purpose: Types shared by the disk controller mode block.
// Assumes: Constants come from dcm_consts.svh.
// Notes: Structs carry grouped configuration and drive inputs.
package dcm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SPEC = 2'b01,
    ST_SUS = 2'b10
  } dcm_state_type;

  // Decoded configuration driven to the disk side
  typedef struct packed {
    logic ecc_en;
    logic crc_poly_select;
    logic sector_type_select;
    logic crc_preset_ones;
    logic poll_select;
    logic [7:0] pad_byte;
    logic [11:0] data_length;
    logic [3:0] smd_req;
    logic [3:0] step_rate_code;
  } dcm_cfg_type;

  // Raw drive status lines
  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] detail;
    logic [7:0] dtype;
  } dcm_drive_type;

  // Correctable error report from the read datapath
  typedef struct packed {
    logic valid;
    logic [11:0] pos;
    logic [23:0] pattern;
  } dcm_ecc_type;
endpackage

// ### core/dcm_ctrl.sv
// Purpose: Mode decode, unit status sense, error report and auxiliary commands.
// Assumes: Drive status lines are asynchronous; other inputs share core_clk_in.
// Notes: Software reset pulses the internal reset one cycle after the write.
`timescale 1ns/1ps
`include "dcm_consts.svh"
module dcm_ctrl #(
  parameter int STEP_UNIT = `DCM_STEP_UNIT
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire dcm_pkg::dcm_drive_type drive_in,
  input wire dcm_pkg::dcm_ecc_type ecc_err_in,
  input wire logic srq_event_in,
  input wire logic fmt_hung_in,
  input wire logic step_req_in,
  output dcm_pkg::dcm_cfg_type cfg_out,
  output logic step_pulse_out,
  output logic fault_clear_out,
  output logic clear_buffer_out,
  output logic irq_out
);
  import dcm_pkg::*;

  dcm_state_type state_q, state_d;
  logic srst_q;
  logic [1:0] pcnt_q;
  logic [7:0] mode_q, lenh_q, lenl_q, mstage_q, hstage_q;
  logic [23:0] drv_s1_q, drv_s2_q;
  logic [4:0][7:0] res_q;
  logic [2:0] res_cnt_q, res_idx_q;
  logic cmd_end_q, srq_q, hold_q, rrq_q, perr_q, sinv_q, eav_q;
  logic [11:0] eaddr_q;
  logic [23:0] epat_q;
  logic step_pend_q;
  logic [15:0] gap_q;
  logic fc_pend_q, fc_q, clb_q, irq_q, step_q;
  logic [7:0] rdata_q;
  dcm_cfg_type cfg_q, cfg_d;

  // Internal reset: pin or software reset pulse
  wire rst_n_w = reset_n_in & ~srst_q;

  // Register port decode
  wire wr_cmd_w = ce_in & wr_in & (addr_in == `DCM_OFS_CMD);
  wire wr_par_w = ce_in & wr_in & (addr_in == `DCM_OFS_PARAM);
  wire rd_res_w = ce_in & rd_in & (addr_in == `DCM_OFS_RESULT);
  wire [4:0] op_w = wdata_in[7:3];
  wire aux_w = wr_cmd_w & (wdata_in[7:4] == `DCM_OP_AUX);
  wire srst_w = aux_w & wdata_in[`DCM_AUX_RST];
  wire clear_cmd_end_w = aux_w & wdata_in[`DCM_AUX_CLEAR_CMD_END];
  wire hold_service_req_w = aux_w & wdata_in[`DCM_AUX_HOLD_SERVICE_REQ];
  wire clb_w = aux_w & wdata_in[`DCM_AUX_CLB];
  wire cmd_ok_w = wr_cmd_w & ~aux_w & (state_q == ST_IDLE);
  wire soft_w = mode_q[`DCM_MB_SECTOR_TYPE_SELECT];

  // Command starts
  wire spec_go_w = cmd_ok_w & (op_w == `DCM_OP_SPECIFY);
  wire sus_soft_w = cmd_ok_w & (op_w == `DCM_OP_SUS) & soft_w;
  wire sus_smd_go_w = cmd_ok_w & (op_w == `DCM_OP_SUS) & ~soft_w;
  wire det_w = cmd_ok_w & (op_w == `DCM_OP_DETECT_ERR);
  wire sint_w = cmd_ok_w & (op_w == `DCM_OP_SENSE_INT);

  // Specify parameters: mode, length high, length low
  wire par_spec_w = wr_par_w & (state_q == ST_SPEC);
  wire msb_ok_w = ((pcnt_q == 2'd0) & ~wdata_in[7]) | ((pcnt_q == 2'd1) & wdata_in[7])
                  | (pcnt_q == 2'd2);
  wire spec_bad_w = par_spec_w & ~msb_ok_w;
  wire spec_last_w = par_spec_w & msb_ok_w & (pcnt_q == 2'd2);
  wire [11:0] new_len_w = {hstage_q[3:0], wdata_in};
  wire [11:0] len_min_w = mstage_q[`DCM_MB_SECTOR_TYPE_SELECT] ? `DCM_LEN_MIN_SOFT : `DCM_LEN_MIN_HARD;
  wire len_ok_w = new_len_w >= len_min_w;
  wire commit_w = spec_last_w & len_ok_w;

  // Module-mode unit status parameter
  wire par_sus_w = wr_par_w & (state_q == ST_SUS);
  wire sus_sel_ok_w = (wdata_in == `DCM_SUS_UST) | (wdata_in == `DCM_SUS_DS)
                      | (wdata_in == `DCM_SUS_DT);
  wire sus_fire_w = par_sus_w & sus_sel_ok_w;

  // Command completion and result loading
  wire cmd_done_w = spec_bad_w | spec_last_w | par_sus_w | sus_soft_w | det_w | sint_w;
  wire load_w = sus_soft_w | sus_fire_w | det_w;

  // Unit status formatting per interface type
  wire [7:0] u_w = drv_s2_q[23:16];
  wire [7:0] ust_smd_w = {u_w[7:5], 1'b0, u_w[3:0]};
  wire [7:0] ust_stp_w = {3'b000, u_w[4:0]};
  wire [7:0] sus_byte_w = sus_soft_w ? ust_stp_w :
                          (wdata_in == `DCM_SUS_DS) ? drv_s2_q[15:8] :
                          (wdata_in == `DCM_SUS_DT) ? drv_s2_q[7:0] : ust_smd_w;
  wire [39:0] res_ld_w = det_w ?
    {epat_q[7:0], epat_q[15:8], epat_q[23:16], eaddr_q[7:0], {4'h0, eaddr_q[11:8]}} :
    {32'h0, sus_byte_w};
  wire [2:0] ld_cnt_w = det_w ? 3'd5 : 3'd1;
  wire pop_w = rd_res_w & (res_idx_q < res_cnt_q);

  // Error address measured back from the last data byte
  wire [11:0] eaddr_d_w = cfg_q.data_length - 12'd1 - ecc_err_in.pos;

  // Step spacing from the rate code
  wire [15:0] gap_w = 16'((`DCM_STEP_BASE - 32'(mode_q[3:0])) * STEP_UNIT);
  wire step_go_w = step_pend_q & (gap_q == 16'h0) & soft_w;

  // Read data select
  wire [7:0] stat_w = {eav_q, sinv_q, perr_q, (state_q != ST_IDLE),
                       (res_idx_q < res_cnt_q), rrq_q, srq_q, cmd_end_q};
  wire [7:0] rd_sel_w =
    (addr_in == `DCM_OFS_RESULT) ? (pop_w ? res_q[res_idx_q] : 8'h00) :
    (addr_in == `DCM_OFS_STATUS) ? stat_w :
    (addr_in == `DCM_OFS_MODE) ? mode_q :
    (addr_in == `DCM_OFS_LENH) ? lenh_q :
    (addr_in == `DCM_OFS_LENL) ? lenl_q : 8'h00;

  // Decoded configuration
  always_comb begin
    cfg_d.ecc_en = mode_q[`DCM_MB_ECC];
    cfg_d.crc_poly_select = mode_q[`DCM_MB_CRC_POLY_SELECT];
    cfg_d.sector_type_select = mode_q[`DCM_MB_SECTOR_TYPE_SELECT];
    cfg_d.crc_preset_ones = lenh_q[`DCM_LB_CRC];
    cfg_d.poll_select = lenh_q[`DCM_LB_POL];
    cfg_d.pad_byte = lenh_q[`DCM_LB_PAD] ? `DCM_PAD_FILL : `DCM_PAD_ZERO;
    cfg_d.data_length = {lenh_q[3:0], lenl_q};
    cfg_d.smd_req = soft_w ? 4'h0 : mode_q[3:0];
    cfg_d.step_rate_code = soft_w ? mode_q[3:0] : 4'h0;
  end

  // Command sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (spec_go_w) begin
          state_d = ST_SPEC;
        end else if (sus_smd_go_w) begin
          state_d = ST_SUS;
        end
      end
      ST_SPEC: begin
        if (spec_bad_w | spec_last_w) begin
          state_d = ST_IDLE;
        end
      end
      ST_SUS: begin
        if (par_sus_w) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Software reset pulse, lasts one enabled cycle; async reset only by the pin
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      srst_q <= 1'b0;
    end else if (ce_in) begin
      srst_q <= srst_w;
    end
  end

  // Drive status synchroniser
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      drv_s1_q <= 24'h0;
      drv_s2_q <= 24'h0;
    end else if (ce_in) begin
      drv_s1_q <= drive_in;
      drv_s2_q <= drv_s1_q;
    end
  end

  // State, parameter count and staged specify bytes
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      state_q <= ST_IDLE;
      pcnt_q <= 2'd0;
      mstage_q <= `DCM_MODE_RST;
      hstage_q <= `DCM_LENH_RST;
    end else if (ce_in) begin
      state_q <= state_d;
      pcnt_q <= par_spec_w ? pcnt_q + 2'd1 : (spec_go_w ? 2'd0 : pcnt_q);
      if (par_spec_w & (pcnt_q == 2'd0)) mstage_q <= wdata_in;
      if (par_spec_w & (pcnt_q == 2'd1)) hstage_q <= wdata_in;
    end
  end

  // Mode and length registers, updated only by a valid specify
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      mode_q <= `DCM_MODE_RST;
      lenh_q <= `DCM_LENH_RST;
      lenl_q <= `DCM_LENL_RST;
    end else if (ce_in && commit_w) begin
      mode_q <= mstage_q;
      lenh_q <= hstage_q;
      lenl_q <= wdata_in;
    end
  end

  // Result bytes toward the host
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      res_q <= 40'h0;
      res_cnt_q <= 3'd0;
      res_idx_q <= 3'd0;
    end else if (ce_in) begin
      if (load_w) begin
        res_q <= res_ld_w;
        res_cnt_q <= ld_cnt_w;
        res_idx_q <= 3'd0;
      end else if (pop_w) begin
        res_idx_q <= res_idx_q + 3'd1;
      end
    end
  end

  // Status flags; hardware set wins over clear
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      cmd_end_q <= 1'b0;
      srq_q <= 1'b0;
      hold_q <= 1'b0;
      rrq_q <= 1'b0;
      perr_q <= 1'b0;
      sinv_q <= 1'b0;
    end else if (ce_in) begin
      cmd_end_q <= cmd_done_w | (cmd_end_q & ~clear_cmd_end_w & ~cmd_ok_w);
      srq_q <= srq_event_in | (srq_q & ~sint_w);
      hold_q <= ~cmd_done_w & (hold_service_req_w | hold_q);
      rrq_q <= rrq_q | fmt_hung_in;
      perr_q <= (spec_bad_w | (spec_last_w & ~len_ok_w)) | (perr_q & ~spec_go_w);
      sinv_q <= (par_sus_w & ~sus_sel_ok_w) | (sinv_q & ~cmd_ok_w);
    end
  end

  // Correctable error latch
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      eaddr_q <= 12'h0;
      epat_q <= 24'h0;
      eav_q <= 1'b0;
    end else if (ce_in) begin
      if (ecc_err_in.valid) begin
        eaddr_q <= eaddr_d_w;
        epat_q <= ecc_err_in.pattern;
      end
      eav_q <= ecc_err_in.valid | (eav_q & ~det_w);
    end
  end

  // Step pulse spacing; a new request during the gap waits
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      step_pend_q <= 1'b0;
      gap_q <= 16'h0;
      step_q <= 1'b0;
    end else if (ce_in) begin
      step_pend_q <= soft_w & (step_req_in | (step_pend_q & ~step_go_w));
      gap_q <= step_go_w ? gap_w - 16'h1 : (gap_q != 16'h0 ? gap_q - 16'h1 : 16'h0);
      step_q <= step_go_w;
    end
  end

  // Output flops
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      fc_pend_q <= 1'b0;
      fc_q <= 1'b0;
      clb_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
      cfg_q <= '0;
    end else if (ce_in) begin
      fc_pend_q <= sus_fire_w;
      fc_q <= fc_pend_q;
      clb_q <= clb_w;
      irq_q <= cmd_end_q | (srq_q & ~hold_q);
      rdata_q <= rd_in ? rd_sel_w : 8'h00;
      cfg_q <= cfg_d;
    end
  end

  assign rdata_out = rdata_q;
  assign cfg_out = cfg_q;
  assign step_pulse_out = step_q;
  assign fault_clear_out = fc_q;
  assign clear_buffer_out = clb_q;
  assign irq_out = irq_q;

  // Assertion helpers: cycles since the last step pulse
  logic [15:0] since_q;
  logic seen_q;
  always_ff @(posedge core_clk_in or negedge rst_n_w) begin
    if (!rst_n_w) begin
      since_q <= 16'h0;
      seen_q <= 1'b0;
    end else if (ce_in) begin
      since_q <= step_q ? 16'h1 : since_q + 16'h1;
      seen_q <= seen_q | step_q;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_w || !ce_in);

  sequence s_fire_smd;
    sus_fire_w && !srst_w;
  endsequence
  sequence s_loaded;
    ##1 (res_cnt_q == 3'd1) ##1 fault_clear_out;
  endsequence

  property p_fault_clear;
    s_fire_smd |-> s_loaded;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault clear late");

  property p_err_ready;
    det_w |-> ##[1:4] (res_cnt_q == 3'd5) && (res_q[0] == {4'h0, $past(eaddr_q[11:8])});
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error report late");

  property p_err_order;
    det_w |=> (res_q[1] == $past(eaddr_q[7:0])) && (res_q[2] == $past(epat_q[23:16]));
  endproperty
  a_err_order: assert property (p_err_order) else $error("error bytes misordered");

  property p_sus_soft;
    sus_soft_w |=> (res_cnt_q == 3'd1) && (res_q[0][7:5] == 3'b000) && (state_q == ST_IDLE);
  endproperty
  a_sus_soft: assert property (p_sus_soft) else $error("soft unit status wrong");

  property p_pad;
    ##1 (cfg_out.pad_byte == ($past(lenh_q[`DCM_LB_PAD]) ? 8'h4E : 8'h00));
  endproperty
  a_pad: assert property (p_pad) else $error("pad byte wrong");

  property p_poly;
    ##1 (cfg_out.crc_poly_select == $past(mode_q[`DCM_MB_CRC_POLY_SELECT]))
        && (cfg_out.ecc_en == $past(mode_q[`DCM_MB_ECC]));
  endproperty
  a_poly: assert property (p_poly) else $error("check select wrong");

  property p_step_gap;
    step_pulse_out && seen_q |-> since_q >= 16'(($past(gap_w, 2)));
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("step pulses too close");

  property p_clear_cmd_end;
    clear_cmd_end_w && !cmd_done_w |=> !cmd_end_q ##1 (irq_out == $past(srq_q & ~hold_q));
  endproperty
  a_clear_cmd_end: assert property (p_clear_cmd_end) else $error("command end not cleared");

  property p_hold;
    hold_q && !cmd_end_q |=> !irq_out;
  endproperty
  a_hold: assert property (p_hold) else $error("held service request raised irq");

  property p_bad_len;
    spec_last_w && !len_ok_w |=> perr_q && (mode_q == $past(mode_q));
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("short length accepted");

endmodule // dcm_ctrl

// ### test/dcm_drive_model.sv
// Purpose: Disk drive stand-in facing the mode and auxiliary command block.
// Assumes: Status lines are static levels apart from the fault latch.
// Notes: Tallies step and fault clear pulses for the bench to judge.
`timescale 1ns/1ps
module dcm_drive_model (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic fault_clear_in,
  input wire logic step_pulse_in,
  output dcm_pkg::dcm_drive_type drive_out,
  output int fault_cnt_out,
  output int step_cnt_out
);
  import dcm_pkg::*;
  logic fault_q;
  // Unit byte has bit 4 set so a forced zero shows; bit 0 is the fault latch
  assign drive_out = {7'h7A, fault_q, 8'h3C, 8'h96};
  // Fault latch drops on a clear request; pulses are counted
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_q <= 1'b1;
      fault_cnt_out <= 0;
      step_cnt_out <= 0;
    end else begin
      if (fault_clear_in) begin
        fault_q <= 1'b0;
        fault_cnt_out <= fault_cnt_out + 1;
      end
      if (step_pulse_in) step_cnt_out <= step_cnt_out + 1;
    end
  end
endmodule // dcm_drive_model

// ### test/disk_ctrl_mode_and_aux_cmds_bench.sv
// Purpose: Self-checking bench for mode decode, unit status, error report and auxiliary commands.
// Assumes: Step spacing unit shortened to 4 clocks.
// Notes: Inputs change by non-blocking assignment after rising edges; checks at falling edges.
`timescale 1ns/1ps
`include "dcm_consts.svh"
module disk_ctrl_mode_and_aux_cmds_bench;
  import dcm_pkg::*;
  localparam int SU = 4;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic srq_event_in = 1'b0;
  logic fmt_hung_in = 1'b0;
  logic step_req_in = 1'b0;
  dcm_ecc_type ecc_err_in = '0;
  dcm_drive_type drive;
  dcm_cfg_type cfg_out, ecfg;
  logic [7:0] rdata_out, d;
  logic step_pulse_out, fault_clear_out, clear_buffer_out, irq_out;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int n_clb = 0;
  int fault_cnt, step_cnt;
  // Clock and cycle bookkeeping
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (clear_buffer_out === 1'b1) n_clb <= n_clb + 1;
  end
  dcm_ctrl #(.STEP_UNIT(SU)) uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .drive_in(drive), .ecc_err_in(ecc_err_in), .srq_event_in(srq_event_in), .fmt_hung_in(fmt_hung_in),
    .step_req_in(step_req_in), .cfg_out(cfg_out), .step_pulse_out(step_pulse_out),
    .fault_clear_out(fault_clear_out), .clear_buffer_out(clear_buffer_out), .irq_out(irq_out));
  dcm_drive_model drv (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .fault_clear_in(fault_clear_out),
    .step_pulse_in(step_pulse_out), .drive_out(drive), .fault_cnt_out(fault_cnt), .step_cnt_out(step_cnt));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    d = rdata_out;
  endtask
  task automatic spec(input logic [7:0] m, input logic [7:0] h, input logic [7:0] l);
    wr(`DCM_OFS_CMD, 8'h20);
    wr(`DCM_OFS_PARAM, m);
    wr(`DCM_OFS_PARAM, h);
    wr(`DCM_OFS_PARAM, l);
    tick(3);
  endtask
  // Requests one step and reports the cycle of the pulse, or -1
  task automatic step(output int t);
    @(posedge core_clk_in);
    step_req_in <= 1'b1;
    @(posedge core_clk_in);
    step_req_in <= 1'b0;
    t = -1;
    for (int i = 0; i < 80 && t < 0; i++) begin
      @(negedge core_clk_in);
      if (step_pulse_out === 1'b1) t = cyc;
    end
  endtask
  task automatic pulse_srq;
    @(posedge core_clk_in);
    srq_event_in <= 1'b1;
    @(posedge core_clk_in);
    srq_event_in <= 1'b0;
    tick(2);
  endtask
  task automatic t_reset;
    ecfg = {5'b0, 8'h00, 12'h100, 8'h00};
    chk(cfg_out, ecfg);
    rd(8'h1C);
    chk(d, 8'h00);
  endtask
  task automatic t_spec_soft;
    spec(8'h5A, 8'hF2, 8'h34);
    ecfg = {5'b10111, 8'h4E, 12'h234, 4'h0, 4'hA};
    chk(cfg_out, ecfg);
    rd(`DCM_OFS_MODE);
    chk(d, 8'h5A);
  endtask
  task automatic t_step;
    int t0, t1;
    step(t0);
    step(t1);
    // The model counts a pulse on the edge after it stands
    tick(2);
    chk(t1 - t0, 6 * SU);
    chk(step_cnt, 2);
  endtask
  task automatic t_sus_soft;
    wr(`DCM_OFS_CMD, 8'h30);
    rd(`DCM_OFS_RESULT);
    chk(d, 8'h15);
    rd(`DCM_OFS_STATUS);
    chk(d[4], 1'b0);
  endtask
  task automatic t_ecc;
    logic [39:0] e;
    logic [39:0] g;
    e = {4'h0, 12'h223, 24'hA5C3F0};
    g = 40'h0;
    @(posedge core_clk_in);
    ecc_err_in <= {1'b1, 12'h010, 24'hA5C3F0};
    @(posedge core_clk_in);
    ecc_err_in <= '0;
    rd(`DCM_OFS_STATUS);
    chk(d[7], 1'b1);
    wr(`DCM_OFS_CMD, 8'h50);
    rd(`DCM_OFS_STATUS);
    chk(d[3], 1'b1);
    for (int i = 0; i < 5; i++) begin
      rd(`DCM_OFS_RESULT);
      chk(d, e[39 - 8 * i -: 8]);
      g[39 - 8 * i -: 8] = d;
    end
    // Host repairs stored bytes by XOR with the returned pattern
    chk(g[23:0] ^ (24'h123456 ^ 24'hA5C3F0), 24'h123456);
    rd(`DCM_OFS_STATUS);
    chk(d[7], 1'b0);
  endtask
  task automatic t_spec_hard;
    int t;
    spec(8'h2F, 8'h80, 8'hFF);
    chk(cfg_out, ecfg);
    rd(`DCM_OFS_STATUS);
    chk(d[5], 1'b1);
    spec(8'h2F, 8'h81, 8'h00);
    ecfg = {5'b01000, 8'h00, 12'h100, 4'hF, 4'h0};
    chk(cfg_out, ecfg);
    step(t);
    chk(t < 0, 1'b1);
  endtask
  task automatic t_sus_mod;
    logic [31:0] pv;
    logic [23:0] ev;
    pv = 32'h01020503; // Host passes 1, 2, 5 and one refused value
    ev = 24'hE53C96;
    for (int i = 0; i < 4; i++) begin
      wr(`DCM_OFS_CMD, 8'h30);
      wr(`DCM_OFS_PARAM, pv[31 - 8 * i -: 8]);
      tick(4);
      if (i < 3) begin
        rd(`DCM_OFS_RESULT);
        chk(d, ev[23 - 8 * i -: 8]);
        chk(fault_cnt, i + 1);
      end
    end
    rd(`DCM_OFS_STATUS);
    chk(d[6], 1'b1);
  endtask
  task automatic t_aux;
    int c;
    spec(8'h2F, 8'h81, 8'h00);
    chk(irq_out, 1'b1);
    wr(`DCM_OFS_CMD, 8'h20);
    wr(`DCM_OFS_CMD, 8'h01);
    tick(2);
    chk(irq_out, 1'b0);
    wr(`DCM_OFS_PARAM, 8'h2F);
    wr(`DCM_OFS_PARAM, 8'h81);
    wr(`DCM_OFS_PARAM, 8'h00);
    tick(2);
    chk(irq_out, 1'b1);
    wr(`DCM_OFS_CMD, 8'h01);
    tick(2);
    chk(irq_out, 1'b0);
    pulse_srq();
    chk(irq_out, 1'b1);
    wr(`DCM_OFS_CMD, 8'h02);
    tick(2);
    chk(irq_out, 1'b0);
    rd(`DCM_OFS_STATUS);
    chk(d[1], 1'b1);
    wr(`DCM_OFS_CMD, 8'h10);
    wr(`DCM_OFS_CMD, 8'h01);
    pulse_srq();
    chk(irq_out, 1'b1);
    c = n_clb;
    // A write while the clock enable is low must be ignored
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    wr(`DCM_OFS_CMD, 8'h04);
    ce_in <= 1'b1;
    tick(3);
    chk(n_clb - c, 0);
    wr(`DCM_OFS_CMD, 8'h04);
    tick(3);
    chk(n_clb - c, 1);
    @(posedge core_clk_in);
    fmt_hung_in <= 1'b1;
    @(posedge core_clk_in);
    fmt_hung_in <= 1'b0;
    rd(`DCM_OFS_STATUS);
    chk(d[2], 1'b1);
    wr(`DCM_OFS_CMD, 8'h08);
    tick(4);
    rd(`DCM_OFS_STATUS);
    chk(d, 8'h00);
    chk(irq_out, 1'b0);
    ecfg = {5'b0, 8'h00, 12'h100, 8'h00};
    chk(cfg_out, ecfg);
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    tick(3);
    t_reset();
    t_spec_soft();
    t_step();
    t_sus_soft();
    t_ecc();
    t_spec_hard();
    t_sus_mod();
    t_aux();
    end_sim();
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_fail++;
    end_sim();
  end
endmodule // disk_ctrl_mode_and_aux_cmds_bench
